//--- inc/mps_pkg.sv
/*
  mps_pkg: shared constants and types for the modem power state sequencer and its host end.
  Assumes a single 40 MHz clock shared by both ends.
*/
package mps_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  // recovery and profile times, as printed
  localparam int unsigned OFF_WAKE_MS    = 25;
  localparam int unsigned HIB_WAKE_MS    = 20;
  localparam int unsigned DOZE_WAKE_US   = 300;
  localparam int unsigned WARMUP_US      = 144;
  localparam int unsigned CCA_US         = 134;
  localparam int unsigned ED_US          = 198;
  // cycle counts derived from the clock rate
  localparam int unsigned OFF_WAKE_CYC   = OFF_WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned HIB_WAKE_CYC   = HIB_WAKE_MS * (CLK_HZ / 1000);
  localparam int unsigned DOZE_WAKE_CYC  = DOZE_WAKE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WARMUP_CYC     = WARMUP_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CCA_CYC        = CCA_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ED_CYC         = ED_US * (CLK_HZ / 1_000_000);
  // default clock output divider: 40 MHz / (2 x 610 half period) ~ 32.787 kHz
  localparam int unsigned MODEM_CLOCK_OUT_HALF_DEF  = 610;
  localparam int unsigned CNT_W          = 24;
  localparam int unsigned DIV_W          = 16;
  localparam logic [DIV_W-1:0] MODEM_CLOCK_OUT_HALF_RST = DIV_W'(MODEM_CLOCK_OUT_HALF_DEF);

  typedef enum logic [2:0] {
    MPS_PS_OFF,
    MPS_PS_HIBERNATE,
    MPS_PS_DOZE,
    MPS_PS_IDLE,
    MPS_PS_ACTIVE
  } mps_power_e;

  typedef enum logic [2:0] {
    MPS_OP_NONE,
    MPS_OP_CCA,
    MPS_OP_ED,
    MPS_OP_RX,
    MPS_OP_TX,
    MPS_OP_HIBERNATE,
    MPS_OP_DOZE
  } mps_op_e;
endpackage

//--- inc/mps_link_if.sv
/*
  mps_link_if: pins between the host and the modem sequencer.
  Assumes both ends run on the same clock; the testbench joins them.
*/
`timescale 1ns/1ps
interface mps_link_if;
  import mps_pkg::*;
  logic         reset_n;          // host drives; low holds modem Off
  logic         attention_n;      // host drives; low wakes modem
  logic         op_valid;         // host programs one operation
  mps_op_e      op_code;
  logic         op_ready;         // modem accepts operations
  logic         modem_clock_out_keep_doze;   // keep clock running in doze
  logic         modem_clock_out_enable;      // clock output enable
  logic         attention_n_irq_en;      // attention interrupt enable
  logic [15:0]  modem_clock_out_half;        // clock output half period in cycles
  logic [23:0]  doze_time;        // doze wake timer, cycles
  logic [15:0]  op_len;           // rx/tx length, cycles
  logic         attention_n_irq;         // modem attention interrupt pulse
  logic         timer_irq;        // modem timer interrupt pulse
  logic         op_done;          // operation back in idle, pulse
  logic         modem_clock_out;
  mps_power_e   power_state;

  modport modem (input reset_n, attention_n, op_valid, op_code, modem_clock_out_keep_doze, modem_clock_out_enable,
                 attention_n_irq_en, modem_clock_out_half, doze_time, op_len,
                 output op_ready, attention_n_irq, timer_irq, op_done, modem_clock_out, power_state);
  modport host (output reset_n, attention_n, op_valid, op_code, modem_clock_out_keep_doze, modem_clock_out_enable,
                attention_n_irq_en, modem_clock_out_half, doze_time, op_len,
                input op_ready, attention_n_irq, timer_irq, op_done, modem_clock_out, power_state);
endinterface

//--- src/mps_modem.sv
/*
  mps_modem: modem power state sequencer (low-power states, wake, clock output, active ops).
  Assumes the host end drives the link pins from this same clock (only reset and attention pins synchronised here).
*/
// What this block does
// - reset release: idle, attention irq, clock within 25ms
// - attention low leaves hibernate within 20ms
// - hibernate exit: irq and clock only if enabled
// - doze ends by timer or attention, 300us+period
// - clock optionally runs in doze, restarts after
// - doze exit: attention irq or timer irq
// - clock stopped in off and hibernate
// - host releases low power, waits clock
// - every operation starts and ends in idle
// - host programs each operation separately
// - host does cca, tx if clear, rx (host gets no cca result; tx is issued as commanded)
// - assessment starts with 144us warm-up
// - cca 134us, ed 198us, then idle
`timescale 1ns/1ps
module mps_modem
  import mps_pkg::*;
#(parameter int unsigned OFF_START_CYC = OFF_WAKE_CYC,
  parameter int unsigned HIB_START_CYC = HIB_WAKE_CYC) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  mps_link_if.modem link
);
  import mps_pkg::*;

  if (OFF_START_CYC < 1 || OFF_START_CYC > OFF_WAKE_CYC || HIB_START_CYC < 1 || HIB_START_CYC > HIB_WAKE_CYC)
    $error("mps_modem: start-up counts must lie between 1 and the maximum recovery time");
  typedef enum {
    MPS_SQ_OFF, MPS_SQ_WAKE, MPS_SQ_HIB, MPS_SQ_DOZE, MPS_SQ_IDLE, MPS_SQ_WARM, MPS_SQ_MEAS
  } mps_seq_e;

  // three-flop pin synchronisers
  logic [2:0] rst_sync_q, rst_sync_d;
  logic [2:0] attention_n_sync_q, attention_n_sync_d;
  logic       rst_pin_q, rst_pin_d;
  logic       attention_n_pin_q, attention_n_pin_d;
  logic       attention_n_fall;

  always_comb begin
    rst_sync_d  = {rst_sync_q[1:0], link.reset_n};
    attention_n_sync_d = {attention_n_sync_q[1:0], link.attention_n};
    rst_pin_d   = (rst_sync_q[2] == rst_sync_q[1]) ? rst_sync_q[2] : rst_pin_q;
    attention_n_pin_d  = (attention_n_sync_q[2] == attention_n_sync_q[1]) ? attention_n_sync_q[2] : attention_n_pin_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q  <= 3'h0;
      attention_n_sync_q <= 3'h7;
      rst_pin_q   <= 1'b0;
      attention_n_pin_q  <= 1'b1;
    end else begin
      rst_sync_q  <= rst_sync_d;
      attention_n_sync_q <= attention_n_sync_d;
      rst_pin_q   <= rst_pin_d;
      attention_n_pin_q  <= attention_n_pin_d;
    end
  end

  assign attention_n_fall = attention_n_pin_q && !attention_n_pin_d;

  // sequencer state
  mps_seq_e         seq_q, seq_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             from_off_q, from_off_d;
  logic             hib_wake_q, hib_wake_d;
  logic             by_attention_n_q, by_attention_n_d;
  logic             clk_run_q, clk_run_d;
  logic [DIV_W-1:0] half_q, half_d;
  logic             attention_n_irq_q, attention_n_irq_d;
  logic             timer_irq_q, timer_irq_d;
  logic             done_q, done_d;
  logic             keep_doze_q, keep_doze_d;

  always_comb begin
    seq_d       = seq_q;
    cnt_d       = cnt_q;
    from_off_d  = from_off_q;
    hib_wake_d  = hib_wake_q;
    by_attention_n_d   = by_attention_n_q;
    clk_run_d   = clk_run_q;
    half_d      = half_q;
    attention_n_irq_d  = 1'b0;
    timer_irq_d = 1'b0;
    done_d      = 1'b0;
    keep_doze_d = keep_doze_q;
    if (!rst_pin_q) begin
      seq_d     = MPS_SQ_OFF;
      clk_run_d = 1'b0;
      half_d    = MODEM_CLOCK_OUT_HALF_RST;
    end else begin
      case (seq_q)
        MPS_SQ_OFF: begin
          seq_d      = MPS_SQ_WAKE;
          cnt_d      = CNT_W'(OFF_START_CYC - 1);
          from_off_d = 1'b1;
          hib_wake_d = 1'b0;
        end
        MPS_SQ_HIB: begin
          clk_run_d = 1'b0;
          if (attention_n_fall) begin
            seq_d      = MPS_SQ_WAKE;
            cnt_d      = CNT_W'(HIB_START_CYC - 1);
            from_off_d = 1'b0;
            hib_wake_d = 1'b1;
          end
        end
        MPS_SQ_DOZE: begin
          clk_run_d = keep_doze_q && link.modem_clock_out_enable;
          if (!hib_wake_q && (attention_n_fall || cnt_q == '0)) begin
            hib_wake_d = 1'b1;
            by_attention_n_d  = attention_n_fall;
            cnt_d      = CNT_W'(DOZE_WAKE_CYC) + CNT_W'(half_q) + CNT_W'(half_q) - 1'b1;
          end else if (hib_wake_q) begin
            if (cnt_q == '0) begin
              seq_d       = MPS_SQ_IDLE;
              hib_wake_d  = 1'b0;
              clk_run_d   = 1'b1;
              attention_n_irq_d  = by_attention_n_q && link.attention_n_irq_en;
              timer_irq_d = !by_attention_n_q;
            end else begin
              cnt_d = cnt_q - 1'b1;
            end
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        MPS_SQ_WAKE: begin
          if (cnt_q == '0) begin
            seq_d = MPS_SQ_IDLE;
            if (from_off_q) begin
              attention_n_irq_d = 1'b1;
              clk_run_d  = 1'b1;
            end else begin
              attention_n_irq_d = link.attention_n_irq_en;
              clk_run_d  = link.modem_clock_out_enable;
            end
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        MPS_SQ_IDLE: begin
          clk_run_d = link.modem_clock_out_enable;
          half_d    = (link.modem_clock_out_half == '0) ? half_q : link.modem_clock_out_half;
          if (link.op_valid) begin
            case (link.op_code)
              MPS_OP_CCA, MPS_OP_ED: begin
                seq_d     = MPS_SQ_WARM;
                cnt_d     = CNT_W'(WARMUP_CYC - 1);
                by_attention_n_d = (link.op_code == MPS_OP_ED);
              end
              MPS_OP_RX, MPS_OP_TX: begin
                seq_d     = MPS_SQ_MEAS;
                cnt_d     = CNT_W'(WARMUP_CYC) + CNT_W'(link.op_len);
                by_attention_n_d = 1'b0;
              end
              MPS_OP_HIBERNATE: begin
                seq_d     = MPS_SQ_HIB;
                clk_run_d = 1'b0;
              end
              MPS_OP_DOZE: begin
                seq_d       = MPS_SQ_DOZE;
                keep_doze_d = link.modem_clock_out_keep_doze;
                clk_run_d   = link.modem_clock_out_keep_doze && link.modem_clock_out_enable;
                cnt_d       = (link.doze_time == '0) ? '0 : link.doze_time - 1'b1;
                hib_wake_d  = 1'b0;
              end
              default: seq_d = MPS_SQ_IDLE;
            endcase
          end
        end
        MPS_SQ_WARM: begin
          if (cnt_q == '0) begin
            seq_d = MPS_SQ_MEAS;
            cnt_d = by_attention_n_q ? CNT_W'(ED_CYC - 1) : CNT_W'(CCA_CYC - 1);
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        MPS_SQ_MEAS: begin
          if (cnt_q == '0) begin
            seq_d  = MPS_SQ_IDLE;
            done_d = 1'b1;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        default: seq_d = MPS_SQ_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seq_q       <= MPS_SQ_OFF;
      cnt_q       <= '0;
      from_off_q  <= 1'b1;
      hib_wake_q  <= 1'b0;
      by_attention_n_q   <= 1'b0;
      clk_run_q   <= 1'b0;
      half_q      <= MODEM_CLOCK_OUT_HALF_RST;
      attention_n_irq_q  <= 1'b0;
      timer_irq_q <= 1'b0;
      done_q      <= 1'b0;
      keep_doze_q <= 1'b0;
    end else begin
      seq_q       <= seq_d;
      cnt_q       <= cnt_d;
      from_off_q  <= from_off_d;
      hib_wake_q  <= hib_wake_d;
      by_attention_n_q   <= by_attention_n_d;
      clk_run_q   <= clk_run_d;
      half_q      <= half_d;
      attention_n_irq_q  <= attention_n_irq_d;
      timer_irq_q <= timer_irq_d;
      done_q      <= done_d;
      keep_doze_q <= keep_doze_d;
    end
  end

  // clock output divider
  logic [DIV_W-1:0] div_q, div_d;
  logic             modem_clock_out_q, modem_clock_out_d;

  always_comb begin
    div_d  = div_q;
    modem_clock_out_d = modem_clock_out_q;
    if (!clk_run_q) begin
      div_d  = '0;
      modem_clock_out_d = 1'b0;
    end else if (div_q >= half_q - 1'b1) begin
      div_d  = '0;
      modem_clock_out_d = !modem_clock_out_q;
    end else begin
      div_d = div_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q  <= '0;
      modem_clock_out_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      modem_clock_out_q <= modem_clock_out_d;
    end
  end

  mps_power_e ps;
  always_comb begin
    case (seq_q)
      MPS_SQ_OFF:              ps = MPS_PS_OFF;
      MPS_SQ_HIB:              ps = MPS_PS_HIBERNATE;
      MPS_SQ_WAKE:             ps = from_off_q ? MPS_PS_OFF : MPS_PS_HIBERNATE;
      MPS_SQ_DOZE:             ps = MPS_PS_DOZE;
      MPS_SQ_IDLE:             ps = MPS_PS_IDLE;
      default:                 ps = MPS_PS_ACTIVE;
    endcase
  end

  assign link.power_state     = ps;
  assign link.op_ready        = (seq_q == MPS_SQ_IDLE);
  assign link.attention_n_irq        = attention_n_irq_q;
  assign link.timer_irq       = timer_irq_q;
  assign link.op_done         = done_q;
  assign link.modem_clock_out = modem_clock_out_q;
endmodule // mps_modem

//--- src/mps_host.sv
/*
  mps_host: host end; drives modem reset, attention and one operation at a time.
  Assumes the modem end sits on the same clock and answers over mps_link_if.
*/
`timescale 1ns/1ps
module mps_host
  import mps_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             modem_on_i,
  input  wire logic             wake_i,
  input  wire logic             cmd_valid_i,
  input  wire mps_pkg::mps_op_e cmd_op_i,
  input  wire logic [15:0]      cmd_len_i,
  input  wire logic [23:0]      doze_time_i,
  input  wire logic [15:0]      modem_clock_out_half_i,
  input  wire logic             modem_clock_out_enable_i,
  input  wire logic             modem_clock_out_keep_doze_i,
  input  wire logic             attention_n_irq_en_i,
  output logic                  cmd_ready_o,
  output logic                  cmd_done_o,
  output logic                  clock_ok_o,
  output mps_pkg::mps_power_e   power_state_o,
  mps_link_if.host              link
);
  import mps_pkg::*;

  logic       attention_n_q, attention_n_d;
  logic       busy_q, busy_d;
  logic       valid_q, valid_d;
  mps_op_e    op_q, op_d;
  logic [15:0] len_q, len_d;
  logic       clk_seen_q, clk_seen_d;
  logic       done_q, done_d;

  always_comb begin
    attention_n_d     = !wake_i;
    valid_d    = 1'b0;
    op_d       = op_q;
    len_d      = len_q;
    busy_d     = busy_q;
    done_d     = link.op_done;
    clk_seen_d = clk_seen_q;
    if (link.modem_clock_out)
      clk_seen_d = 1'b1;
    if (link.power_state == MPS_PS_OFF || link.power_state == MPS_PS_HIBERNATE)
      clk_seen_d = 1'b0;
    if (busy_q && link.op_ready && !valid_q)
      busy_d = 1'b0;
    if (cmd_valid_i && cmd_ready_o) begin
      valid_d = 1'b1;
      op_d    = cmd_op_i;
      len_d   = cmd_len_i;
      busy_d  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      attention_n_q     <= 1'b1;
      busy_q     <= 1'b0;
      valid_q    <= 1'b0;
      op_q       <= MPS_OP_NONE;
      len_q      <= 16'h0000;
      clk_seen_q <= 1'b0;
      done_q     <= 1'b0;
    end else begin
      attention_n_q     <= attention_n_d;
      busy_q     <= busy_d;
      valid_q    <= valid_d;
      op_q       <= op_d;
      len_q      <= len_d;
      clk_seen_q <= clk_seen_d;
      done_q     <= done_d;
    end
  end

  // one operation at a time, only when the modem rests in idle
  assign cmd_ready_o         = link.op_ready && !busy_q && !valid_q;
  assign cmd_done_o          = done_q;
  assign clock_ok_o          = clk_seen_q;
  assign power_state_o       = link.power_state;
  assign link.reset_n        = modem_on_i;
  assign link.attention_n    = attention_n_q;
  assign link.op_valid       = valid_q;
  assign link.op_code        = op_q;
  assign link.op_len         = len_q;
  assign link.doze_time      = doze_time_i;
  assign link.modem_clock_out_half      = modem_clock_out_half_i;
  assign link.modem_clock_out_enable    = modem_clock_out_enable_i;
  assign link.modem_clock_out_keep_doze = modem_clock_out_keep_doze_i;
  assign link.attention_n_irq_en    = attention_n_irq_en_i;
endmodule // mps_host

//--- verif/mps_checker.sv
/* mps_checker: timing and state checks on the host-modem link.
   Assumes one clock and the signal names of mps_link_if. */
`timescale 1ns/1ps
module mps_checker
  import mps_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_b_i,
  input wire logic                 op_valid,
  input wire mps_pkg::mps_op_e     op_code,
  input wire logic                 op_ready,
  input wire logic [15:0]          op_len,
  input wire logic                 attention_n_irq_en,
  input wire logic                 attention_n_irq,
  input wire logic                 timer_irq,
  input wire logic                 op_done,
  input wire logic                 modem_clock_out,
  input wire mps_pkg::mps_power_e  power_state
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [31:0] cnt_q, cnt_d, exp_t;
  logic [15:0] len_q, len_d;
  mps_op_e     kind_q, kind_d;
  mps_power_e  lp_q, lp_d;
  logic        take, low;
  assign take = op_valid && op_ready;
  assign low  = power_state inside {MPS_PS_OFF, MPS_PS_HIBERNATE};
  // cycles since the last accepted operation, and the last low-power state
  always_comb begin
    cnt_d  = take ? 32'h0 : cnt_q + 32'h1;
    kind_d = take ? op_code : kind_q;
    len_d  = take ? op_len : len_q;
    lp_d   = (low || power_state == MPS_PS_DOZE) ? power_state : lp_q;
    exp_t  = WARMUP_CYC + (kind_q == MPS_OP_CCA ? CCA_CYC : kind_q == MPS_OP_ED ? ED_CYC : 32'(len_q));
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q  <= '0;
      kind_q <= MPS_OP_NONE;
      len_q  <= '0;
      lp_q   <= MPS_PS_OFF;
    end else begin
      cnt_q  <= cnt_d;
      kind_q <= kind_d;
      len_q  <= len_d;
      lp_q   <= lp_d;
    end
  end
  sequence s_off_exit;
    $past(power_state) == MPS_PS_OFF && power_state == MPS_PS_IDLE;
  endsequence
  // the first output edge follows one default half period after start-up
  localparam int CLK_FIRST_MAX = MODEM_CLOCK_OUT_HALF_DEF + 2;
  sequence s_irq_then_clk;
    ##[0:2] attention_n_irq ##[1:CLK_FIRST_MAX] $changed(modem_clock_out);
  endsequence
  property p_clk_stopped;
    low && $past(low) && $past(low, 2) |-> $stable(modem_clock_out);
  endproperty
  a_clk_stopped: assert property (p_clk_stopped) else $error("clock output moved in off or hibernate");
  property p_ready_idle;
    op_ready |-> power_state == MPS_PS_IDLE;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready outside idle");
  property p_start_idle;
    take && op_code inside {MPS_OP_CCA, MPS_OP_ED, MPS_OP_RX, MPS_OP_TX}
      |-> power_state == MPS_PS_IDLE ##[1:2] power_state == MPS_PS_ACTIVE;
  endproperty
  a_start_idle: assert property (p_start_idle) else $error("operation did not start from idle");
  property p_done_idle;
    op_done |-> ##[0:2] power_state == MPS_PS_IDLE;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("operation did not return to idle");
  property p_op_time;
    op_done |-> cnt_q + 32'h3 >= exp_t && cnt_q <= exp_t + 32'h3;
  endproperty
  a_op_time: assert property (p_op_time) else $error("operation length wrong");
  property p_off_exit;
    s_off_exit |-> s_irq_then_clk;
  endproperty
  a_off_exit: assert property (p_off_exit) else $error("no interrupt or clock after off exit");
  property p_timer_src;
    timer_irq |-> lp_q == MPS_PS_DOZE;
  endproperty
  a_timer_src: assert property (p_timer_src) else $error("timer interrupt outside doze exit");
  property p_attention_n_en;
    attention_n_irq && lp_q != MPS_PS_OFF |-> attention_n_irq_en;
  endproperty
  a_attention_n_en: assert property (p_attention_n_en) else $error("attention interrupt while disabled");
endmodule // mps_checker

//--- verif/modem_power_state_sequencer_tb.sv
/* modem_power_state_sequencer_tb: host and modem joined over the link, host user side driven.
   Assumes the package cycle counts; modem start-up counts are shortened at the instance. */
`timescale 1ns/1ps
module modem_power_state_sequencer_tb;
  import mps_pkg::*;
  logic        clk_i     = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        modem_on  = 1'b0;
  logic        wake      = 1'b0;
  logic        cmd_valid = 1'b0;
  mps_op_e     cmd_op    = MPS_OP_NONE;
  logic [15:0] cmd_len   = 16'h0000;
  logic [23:0] doze_time = 24'h0000C8;
  logic        keep_doze = 1'b0;
  logic        attention_n_en   = 1'b1;
  logic        modem_clock_out_en   = 1'b1;
  logic [15:0] modem_clock_out_half = 16'h0000;
  // start-up times below the allowed maximum, short enough for the run
  localparam int unsigned OFF_START_T = 4000;
  localparam int unsigned HIB_START_T = 3000;
  logic        cmd_ready, cmd_done, clock_ok;
  mps_power_e  pstate;
  int          failures  = 0;
  int          checks    = 0;
  int          attention_n_seen = 0;
  int          timer_seen = 0;
  int          n, t, xt;
  mps_op_e     ops [4]   = '{MPS_OP_CCA, MPS_OP_TX, MPS_OP_RX, MPS_OP_ED};
  mps_link_if lk ();
  mps_modem #(.OFF_START_CYC(OFF_START_T), .HIB_START_CYC(HIB_START_T)) u_mps_modem (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .link(lk));
  mps_host u_mps_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .modem_on_i(modem_on), .wake_i(wake),
    .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .cmd_len_i(cmd_len), .doze_time_i(doze_time),
    .modem_clock_out_half_i(modem_clock_out_half), .modem_clock_out_enable_i(modem_clock_out_en), .modem_clock_out_keep_doze_i(keep_doze), .attention_n_irq_en_i(attention_n_en),
    .cmd_ready_o(cmd_ready), .cmd_done_o(cmd_done), .clock_ok_o(clock_ok), .power_state_o(pstate), .link(lk));
  mps_checker u_mps_checker (.clk_i(clk_i), .rst_b_i(rst_b_i), .op_valid(lk.op_valid), .op_code(lk.op_code),
    .op_ready(lk.op_ready), .op_len(lk.op_len), .attention_n_irq_en(lk.attention_n_irq_en), .attention_n_irq(lk.attention_n_irq),
    .timer_irq(lk.timer_irq), .op_done(lk.op_done), .modem_clock_out(lk.modem_clock_out),
    .power_state(lk.power_state));
  initial forever #12.5 clk_i = ~clk_i;
  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clk_i) begin
    if (lk.attention_n_irq === 1'b1) attention_n_seen++;
    if (lk.timer_irq === 1'b1) timer_seen++;
  end
  task automatic finish_test();
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    $display("[ERR] wait expected done seen timeout");
    finish_test();
  endtask
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk_range(input string nm, input int lo, input int hi, input int got);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic wait_state(input mps_power_e s, input int max, output int c);
    c = 0;
    while (pstate !== s) begin
      step();
      c++;
      if (c > max) timeout();
    end
  endtask
  task automatic wait_sig(input bit sel, input int max, output int c);
    c = 0;
    while ((sel ? clock_ok : cmd_done) !== 1'b1) begin
      step();
      c++;
      if (c > max) timeout();
    end
  endtask
  task automatic issue(input mps_op_e op, input logic [15:0] len);
    int c;
    c = 0;
    while (cmd_ready !== 1'b1 && c < 50) begin
      step();
      c++;
    end
    chk_range("ready", 0, 49, c);
    cmd_op = op;
    cmd_len = len;
    cmd_valid = 1'b1;
    step();
    cmd_valid = 1'b0;
  endtask
  // counts output clock edges over 1300 cycles, about one default period
  task automatic toggles(output int c);
    logic v;
    c = 0;
    v = lk.modem_clock_out;
    repeat (1300) begin
      step();
      if (lk.modem_clock_out !== v) c++;
      v = lk.modem_clock_out;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    toggles(t);
    chk_range("off clock edges", 0, 0, t);
    chk_bit("off ready", 1'b0, cmd_ready);
    modem_on = 1'b1;
    wait_state(MPS_PS_IDLE, OFF_START_T + 100, n);
    chk_range("off wake", OFF_START_T, OFF_WAKE_CYC, n);
    wait_sig(1'b1, 2 * MODEM_CLOCK_OUT_HALF_DEF + 20, n);
    chk_range("off irq", 1, 1, attention_n_seen);
    foreach (ops[i]) begin
      xt = WARMUP_CYC + (ops[i] == MPS_OP_CCA ? CCA_CYC : ops[i] == MPS_OP_ED ? ED_CYC : 100);
      issue(ops[i], 16'h0064);
      chk_bit("busy ready", 1'b0, cmd_ready);
      wait_sig(1'b0, xt + 20, n);
      chk_range(ops[i].name(), xt - 2, xt + 4, n);
      chk_bit("idle after op", 1'b1, pstate === MPS_PS_IDLE);
    end
    attention_n_seen = 0;
    issue(MPS_OP_DOZE, 16'h0000);
    wait_state(MPS_PS_DOZE, 20, n);
    xt = 200 + DOZE_WAKE_CYC + 2 * MODEM_CLOCK_OUT_HALF_DEF;
    wait_state(MPS_PS_IDLE, xt + 20, n);
    chk_range("timer wake", DOZE_WAKE_CYC, xt + 10, n);
    toggles(t);
    chk_range("clock after doze", 2, 3, t);
    chk_range("timer irq", 1, 1, timer_seen);
    chk_range("no attention_n irq", 0, 0, attention_n_seen);
    doze_time = 24'hFFFFFF;
    keep_doze = 1'b1;
    timer_seen = 0;
    issue(MPS_OP_DOZE, 16'h0000);
    wait_state(MPS_PS_DOZE, 20, n);
    toggles(t);
    chk_range("doze clock", 2, 3, t);
    wake = 1'b1;
    xt = DOZE_WAKE_CYC + 2 * MODEM_CLOCK_OUT_HALF_DEF;
    wait_state(MPS_PS_IDLE, xt + 20, n);
    chk_range("attention_n wake", DOZE_WAKE_CYC, xt + 10, n);
    wake = 1'b0;
    repeat (4) step();
    chk_range("attention_n irq", 1, 1, attention_n_seen);
    chk_range("no timer irq", 0, 0, timer_seen);
    modem_clock_out_half = 16'h0064;
    step();
    // first pass: interrupt off, clock on; second pass: the reverse
    for (int k = 0; k < 2; k++) begin
      attention_n_en = k[0];
      modem_clock_out_en = !k[0];
      issue(MPS_OP_HIBERNATE, 16'h0000);
      wait_state(MPS_PS_HIBERNATE, 20, n);
      repeat (2) step();
      toggles(t);
      chk_range("hibernate clock", 0, 0, t);
      chk_bit("clock ok", 1'b0, clock_ok);
      attention_n_seen = 0;
      wake = 1'b1;
      wait_state(MPS_PS_IDLE, HIB_START_T + 100, n);
      chk_range("hibernate wake", HIB_START_T, HIB_WAKE_CYC, n);
      wake = 1'b0;
      toggles(t);
      chk_range("clock after hibernate", k ? 0 : 12, k ? 0 : 13, t);
      chk_range("hibernate irq", k, k, attention_n_seen);
    end
    modem_on = 1'b0;
    wait_state(MPS_PS_OFF, 10, n);
    finish_test();
  end
endmodule // modem_power_state_sequencer_tb
